// >>> logic/btob_consts.svh
`ifndef BTOB_CONSTS_SVH
`define BTOB_CONSTS_SVH
`define BTOB_OP_INV_HI    4'h7
`define BTOB_OP_OVF_HI    8'he4
`define BTOB_ILO_MAX      8'h5f
`define BTOB_ACC_SPLIT    8'h60
`define BTOB_ACC_HI_BANK  4'hf
`define BTOB_LO_BANK      4'h0
`define BTOB_PC_STEP      21'h000002
`define BTOB_PC_RST       21'h000000
`endif

// >>> logic/btob_pkg.sv
package btob_pkg;
  typedef enum logic [3:0] {
    BTOB_Q1 = 4'b0001,
    BTOB_Q2 = 4'b0010,
    BTOB_Q3 = 4'b0100,
    BTOB_Q4 = 4'b1000
  } btob_phase_t;
endpackage

// >>> logic/btob_core.sv
`timescale 1ns/1ns
`include "btob_consts.svh"
module btob_core (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic [15:0] instr_in,
  input  wire logic        instr_valid_in,
  input  wire logic        ext_set_en_in,
  input  wire logic [3:0]  bank_select_reg_in,
  input  wire logic [11:0] index_base_in,
  input  wire logic        ovf_flag_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [11:0] mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic      [7:0]  mem_wdata_out,
  output logic      [20:0] pc_out,
  output logic             phase_q1_out,
  output logic             busy_out,
  output logic             status_wr_out
);
  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  btob_pkg::btob_phase_t phase_q;
  btob_pkg::btob_phase_t phase_d;
  always_comb begin
    case (phase_q)
      btob_pkg::BTOB_Q1: phase_d = btob_pkg::BTOB_Q2;
      btob_pkg::BTOB_Q2: phase_d = btob_pkg::BTOB_Q3;
      btob_pkg::BTOB_Q3: phase_d = btob_pkg::BTOB_Q4;
      default:           phase_d = btob_pkg::BTOB_Q1;
    endcase
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_q <= btob_pkg::BTOB_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end
  // ----------------------------------------------------------------
  // Decode, latched in Q1
  // ----------------------------------------------------------------
  logic [15:0] ir_q;
  logic [15:0] ir_d;
  logic        idle_q;
  logic        idle_d;
  logic        is_inv;
  logic        is_ovf;
  logic        taken;
  assign is_inv = !idle_q && ir_q[15:12] == `BTOB_OP_INV_HI;
  assign is_ovf = !idle_q && ir_q[15:8] == `BTOB_OP_OVF_HI;
  assign taken  = is_ovf && ovf_flag_in;
  always_comb begin
    ir_d   = ir_q;
    idle_d = idle_q;
    if (phase_q == btob_pkg::BTOB_Q1) begin
      ir_d = instr_in;
    end
    if (phase_q == btob_pkg::BTOB_Q4) begin
      // Taken branch flushes the prefetched word: next cycle is idle
      idle_d = taken || !instr_valid_in;
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ir_q   <= 16'h0000;
      idle_q <= 1'b1;
    end else begin
      ir_q   <= ir_d;
      idle_q <= idle_d;
    end
  end
  // ----------------------------------------------------------------
  // Operand address
  // ----------------------------------------------------------------
  logic [7:0]  f_addr;
  logic [2:0]  bit_sel;
  logic        acc_bit;
  logic [11:0] ea;
  assign f_addr  = ir_q[7:0];
  assign bit_sel = ir_q[11:9];
  assign acc_bit = ir_q[8];
  always_comb begin
    if (acc_bit) begin
      ea = {bank_select_reg_in, f_addr};
    end else if (ext_set_en_in && f_addr <= `BTOB_ILO_MAX) begin
      ea = index_base_in + {4'h0, f_addr};
    end else if (f_addr < `BTOB_ACC_SPLIT) begin
      ea = {`BTOB_LO_BANK, f_addr};
    end else begin
      ea = {`BTOB_ACC_HI_BANK, f_addr};
    end
  end
  // ----------------------------------------------------------------
  // Read-modify-write of the data byte
  // ----------------------------------------------------------------
  logic [7:0]  data_q;
  logic [7:0]  data_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;
  logic        rd_q;
  logic        rd_d;
  logic        wr_q;
  logic        wr_d;
  always_comb begin
    data_d = data_q;
    addr_d = addr_q;
    rd_d   = 1'b0;
    wr_d   = 1'b0;
    case (phase_q)
      btob_pkg::BTOB_Q1: begin
        // Address issued in Q2 so read data is back for Q3
        // A word fetched into a flushed cycle must not touch memory
        if (instr_valid_in && !idle_q &&
            instr_in[15:12] == `BTOB_OP_INV_HI) begin
          rd_d = 1'b1;
        end
      end
      btob_pkg::BTOB_Q2: begin
        if (is_inv) begin
          data_d = mem_rdata_in;
        end
        addr_d = ea;
      end
      btob_pkg::BTOB_Q3: begin
        if (is_inv) begin
          data_d = data_q ^ (8'h01 << bit_sel);
          wr_d   = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_q <= 8'h00;
      addr_q <= 12'h000;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      data_q <= data_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
    end
  end
  // Read strobe in Q2 uses the live address because it forms that phase
  assign mem_addr_out  = (phase_q == btob_pkg::BTOB_Q2) ? ea : addr_q;
  assign mem_rd_out    = rd_q;
  assign mem_wr_out    = wr_q;
  assign mem_wdata_out = data_q;
  assign status_wr_out = 1'b0;
  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic [20:0] pc_q;
  logic [20:0] pc_d;
  logic [20:0] disp2;
  assign disp2 = {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
  always_comb begin
    pc_d = pc_q;
    if (phase_q == btob_pkg::BTOB_Q1 && instr_valid_in) begin
      pc_d = pc_q + `BTOB_PC_STEP;
    end else if (phase_q == btob_pkg::BTOB_Q4 && taken) begin
      pc_d = pc_q + disp2;
    end
  end
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q <= `BTOB_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end
  assign pc_out       = pc_q;
  assign phase_q1_out = phase_q == btob_pkg::BTOB_Q1;
  assign busy_out     = idle_q;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_inv_writeback: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && phase_q == btob_pkg::BTOB_Q2) |=> ##1
      (mem_wr_out && mem_wdata_out ==
       ($past(mem_rdata_in, 2) ^ (8'h01 << bit_sel))))
    else $error("inverted byte wrong");
  chk_bank_reg_addr: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && acc_bit && phase_q == btob_pkg::BTOB_Q2) |->
      mem_addr_out == {bank_select_reg_in, f_addr})
    else $error("bank address wrong");
  chk_access_addr: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && !acc_bit && !ext_set_en_in &&
     phase_q == btob_pkg::BTOB_Q2) |-> mem_addr_out[7:0] == f_addr)
    else $error("access address wrong");
  chk_indexed_addr: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && !acc_bit && ext_set_en_in && f_addr <= `BTOB_ILO_MAX &&
     phase_q == btob_pkg::BTOB_Q2) |->
      mem_addr_out == index_base_in + {4'h0, f_addr})
    else $error("indexed address wrong");
  chk_no_status: assert property (@(posedge mclk_in)
    disable iff (!resetn_in) !status_wr_out)
    else $error("status written");
  chk_branch_target: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (taken && phase_q == btob_pkg::BTOB_Q4) |=>
      pc_out == $past(pc_out) + disp2)
    else $error("branch target wrong");
  chk_not_taken: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_ovf && !ovf_flag_in && phase_q == btob_pkg::BTOB_Q4) |=>
      pc_out == $past(pc_out))
    else $error("untaken branch moved pc");
  chk_idle_cycle: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (taken && phase_q == btob_pkg::BTOB_Q4) |=> busy_out [*4])
    else $error("no idle cycle after branch");
  // ----------------------------------------------------------------
  // Strobe, bank and counter checks
  // ----------------------------------------------------------------
  chk_read_strobe: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    mem_rd_out |-> (is_inv && phase_q == btob_pkg::BTOB_Q2))
    else $error("read strobe outside invert read phase");
  chk_write_phase: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    mem_wr_out |-> (is_inv && phase_q == btob_pkg::BTOB_Q4))
    else $error("write strobe outside invert write phase");
  chk_access_bank: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && !acc_bit && !ext_set_en_in &&
     phase_q == btob_pkg::BTOB_Q2) |->
      mem_addr_out[11:8] == ((f_addr < `BTOB_ACC_SPLIT) ?
                             `BTOB_LO_BANK : `BTOB_ACC_HI_BANK))
    else $error("access bank upper bits wrong");
  chk_pc_step: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (phase_q == btob_pkg::BTOB_Q1 && instr_valid_in) |=>
      pc_out == $past(pc_out) + `BTOB_PC_STEP)
    else $error("pc did not step by one word");
  chk_inv_keeps_pc: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_inv && phase_q == btob_pkg::BTOB_Q4) |=>
      pc_out == $past(pc_out))
    else $error("invert moved pc at end of cycle");
  chk_branch_no_mem: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    is_ovf |-> (!mem_wr_out && !mem_rd_out))
    else $error("branch touched data memory");
  chk_untaken_busy: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (is_ovf && !ovf_flag_in && instr_valid_in &&
     phase_q == btob_pkg::BTOB_Q4) |=> !busy_out)
    else $error("untaken branch inserted idle cycle");
  chk_idle_no_rd: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (phase_q == btob_pkg::BTOB_Q1 && idle_q) |=> !mem_rd_out)
    else $error("flushed word read memory");
  chk_phase_onehot: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    $onehot(phase_q))
    else $error("phase register not one-hot");
endmodule

// >>> testbench/bit_toggle_and_overflow_branch_tb.sv
`timescale 1ns/1ns
module bit_toggle_and_overflow_branch_tb;
  // ----
  // Design hookup
  // ----
  logic        mclk_in            = 1'b0;
  logic        resetn_in          = 1'b0;
  logic [15:0] instr_in           = 16'h0000;
  logic        instr_valid_in     = 1'b0;
  logic        ext_set_en_in      = 1'b0;
  logic [3:0]  bank_select_reg_in = 4'h5;
  logic [11:0] index_base_in      = 12'h300;
  logic        ovf_flag_in        = 1'b0;
  logic [7:0]  mem_rdata_in       = 8'h75;
  logic [11:0] mem_addr_out;
  logic        mem_rd_out;
  logic        mem_wr_out;
  logic [7:0]  mem_wdata_out;
  logic [20:0] pc_out;
  logic        phase_q1_out;
  logic        busy_out;
  logic        status_wr_out;
  int          n_errors = 0;
  int          compares = 0;

  btob_core btob_core_i (
    .mclk_in            (mclk_in),
    .resetn_in          (resetn_in),
    .instr_in           (instr_in),
    .instr_valid_in     (instr_valid_in),
    .ext_set_en_in      (ext_set_en_in),
    .bank_select_reg_in (bank_select_reg_in),
    .index_base_in      (index_base_in),
    .ovf_flag_in        (ovf_flag_in),
    .mem_rdata_in       (mem_rdata_in),
    .mem_addr_out       (mem_addr_out),
    .mem_rd_out         (mem_rd_out),
    .mem_wr_out         (mem_wr_out),
    .mem_wdata_out      (mem_wdata_out),
    .pc_out             (pc_out),
    .phase_q1_out       (phase_q1_out),
    .busy_out           (busy_out),
    .status_wr_out      (status_wr_out)
  );

  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  // ----
  // Shared tasks
  // ----
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [20:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Runs one word; the following word is an unknown opcode, so busy at
  // the next cycle reflects only a taken branch.
  task automatic inst(input logic [15:0] w, input logic rd,
                      input logic [11:0] ad, input logic tk);
    logic [20:0] pc0;
    int          n;
    @(posedge mclk_in);
    instr_in       <= w;
    instr_valid_in <= 1'b1;
    #1;
    n = 0;
    while (phase_q1_out !== 1'b1) begin
      n++;
      if (n > 8) begin
        n_errors++;
        print_verdict();
      end
      @(posedge mclk_in);
      #1;
    end
    pc0 = pc_out;
    @(posedge mclk_in);
    instr_in <= 16'h0000;
    #1;
    chk("mem_rd", mem_rd_out, rd);
    if (rd) chk("mem_addr", mem_addr_out, ad);
    chk("pc_step", pc_out, pc0 + 21'h2);
    repeat (2) @(posedge mclk_in);
    #1;
    chk("mem_wr", mem_wr_out, rd);
    if (rd) chk("wdata", mem_wdata_out, 8'h75 ^ (8'h01 << w[11:9]));
    chk("status_wr", status_wr_out, 1'b0);
    @(posedge mclk_in);
    #1;
    chk("pc_end", pc_out, pc0 + 21'h2 +
        (tk ? {{12{w[7]}}, w[7:0], 1'b0} : 21'h0));
    chk("busy", busy_out, tk);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_bank_reg();
    for (int b = 0; b < 8; b++) begin
      inst({4'h7, b[2:0], 1'b1, 8'ha3}, 1'b1, {4'h5, 8'ha3}, 1'b0);
    end
    $display("bank register test done");
  endtask

  task automatic t_access();
    inst(16'h765f, 1'b1, 12'h05f, 1'b0);
    inst(16'h7260, 1'b1, 12'hf60, 1'b0);
    @(posedge mclk_in);
    ext_set_en_in <= 1'b1;
    inst(16'h785f, 1'b1, 12'h35f, 1'b0);
    inst(16'h7a60, 1'b1, 12'hf60, 1'b0);
    inst(16'h7d10, 1'b1, 12'h510, 1'b0);
    $display("access bank test done");
  endtask

  task automatic t_branch();
    inst(16'he405, 1'b0, 12'h000, 1'b0);
    @(posedge mclk_in);
    ovf_flag_in <= 1'b1;
    inst(16'he47f, 1'b0, 12'h000, 1'b1);
    inst(16'he480, 1'b0, 12'h000, 1'b1);
    $display("overflow branch test done");
  endtask

  // Starts in Q1; a taken branch then an invert word in the flushed
  // cycle, then a cycle with no valid word.
  task automatic t_flush();
    repeat (4) @(posedge mclk_in);
    instr_in <= 16'he4fe;
    @(posedge mclk_in);
    instr_in <= 16'h7101;
    repeat (4) @(posedge mclk_in);
    instr_in       <= 16'h0000;
    instr_valid_in <= 1'b0;
    #1;
    chk("flush_rd", mem_rd_out, 1'b0);
    chk("flush_busy", busy_out, 1'b1);
    repeat (2) @(posedge mclk_in);
    #1;
    chk("flush_wr", mem_wr_out, 1'b0);
    @(posedge mclk_in);
    #1;
    chk("invalid_busy", busy_out, 1'b1);
    $display("flush test done");
  endtask

  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_bank_reg();
    t_access();
    t_branch();
    t_flush();
    print_verdict();
  end
endmodule
